// ---- bus_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_controller (
  input wire logic clk,
  input wire logic dev_oe,
  input wire logic dev_out,
  output var logic scl,
  output var logic sda
);
  logic sc = 1'b1;
  logic sd = 1'b1;
  // clk cycles per drive step (scl high for hl, low for 2*hl per bit); raise it to act as a slow controller
  int hl = 10;
  always_comb begin
    scl = sc;
    sda = sd & ~(dev_oe & ~dev_out);
  end
  task automatic drv(input logic c, input logic d);
    sc <= c;
    sd <= d;
    repeat (hl) @(posedge clk);
  endtask : drv
  task automatic start();
    drv(sc, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask : stop
  // data moves only with scl low and is read at the end of the high phase
  task automatic xfer(input logic b, output logic r);
    drv(1'b0, b);
    drv(1'b1, b);
    r = sda;
    drv(1'b0, b);
  endtask : xfer
  task automatic glitch();
    sc <= 1'b1;
    @(posedge clk);
    sc <= 1'b0;
    repeat (hl) @(posedge clk);
  endtask : glitch
  task automatic io(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
      q[i] = r;
    end
    xfer(ai, ao);
  endtask : io
endmodule : bus_controller
`default_nettype wire

// ---- line_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defines.svh"

module line_filter #(
  parameter int STABLE = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic raw,
  output var logic filt
);

  logic s1_r;
  logic s2_r;
  logic filt_r;
  logic filt_nxt;
  logic [3:0] run_r;
  logic [3:0] run_nxt;

  // a new level is taken only after it has held for STABLE samples
  always_comb begin
    filt_nxt = filt_r;
    run_nxt = 4'h0;
    if (s2_r != filt_r) begin
      run_nxt = run_r + 4'h1;
      if (run_r == 4'(STABLE - 1)) begin
        filt_nxt = s2_r;
        run_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= `SEE_LINE_IDLE;
      s2_r <= `SEE_LINE_IDLE;
      filt_r <= `SEE_LINE_IDLE;
      run_r <= 4'h0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      filt_r <= filt_nxt;
      run_r <= run_nxt;
    end
  end

  assign filt = filt_r;

endmodule : line_filter

`default_nettype wire

// ---- serial_eeprom_defines.svh ----
`ifndef SERIAL_EEPROM_DEFINES_SVH
`define SERIAL_EEPROM_DEFINES_SVH

// array geometry
`define SEE_ADDR_W 13
`define SEE_PAGE_W 5
`define SEE_PAGE_BYTES 32
`define SEE_HI_ADDR_BITS 5
// first byte of the guarded upper quarter
`define SEE_GUARD_BASE 13'h1800

// device address word layout
`define SEE_TYPE_MSB 7
`define SEE_TYPE_LSB 4
`define SEE_SEL_MSB 3
`define SEE_SEL_LSB 1
`define SEE_DIR_BIT 0

// timing
`define SEE_CLK_KHZ 20000
`define SEE_GLITCH_NS 50
`define SEE_PROGRAM_MS 5

// reset values
`define SEE_LINE_IDLE 1'b1
`define SEE_BYTE_RST 8'h00

`endif

// ---- serial_eeprom_i2c_target.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defines.svh"

module serial_eeprom_i2c_target #(
  // arbitrary neutral value for the fixed type code
  parameter logic [3:0] TYPE_CODE = 4'h6,
  parameter int PROGRAM_CYC = `SEE_PROGRAM_MS * `SEE_CLK_KHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe,
  input wire logic write_guard,
  input wire logic select_strap_0,
  input wire logic select_strap_1,
  input wire logic select_strap_2,
  output var logic program_busy
);

  localparam int AW = `SEE_ADDR_W;
  localparam int PW = `SEE_PAGE_W;
  localparam int PAGE = `SEE_PAGE_BYTES;
  localparam int GLITCH_CYC = (`SEE_GLITCH_NS * `SEE_CLK_KHZ + 999999) / 1000000;
  localparam int CW = $clog2(PROGRAM_CYC + 1);

  // next address inside the current page
  function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
    page_inc = {a[AW-1:PW], a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
  endfunction : page_inc

  function automatic logic guarded(input logic [AW-1:0] a, input logic g);
    guarded = g && (a >= `SEE_GUARD_BASE);
  endfunction : guarded

  logic scl_f;
  logic sda_f;
  logic guard_f;
  logic scl_q_r;
  logic sda_q_r;
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;

  line_filter #(.STABLE(GLITCH_CYC + 1)) u_scl_filter (
    .clk(clk),
    .reset_n(reset_n),
    .raw(scl_in),
    .filt(scl_f)
  );

  line_filter #(.STABLE(GLITCH_CYC + 1)) u_sda_filter (
    .clk(clk),
    .reset_n(reset_n),
    .raw(sda_in),
    .filt(sda_f)
  );

  line_filter #(.STABLE(GLITCH_CYC + 1)) u_guard_filter (
    .clk(clk),
    .reset_n(reset_n),
    .raw(write_guard),
    .filt(guard_f)
  );

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_f && !scl_q_r;
  assign scl_fall = !scl_f && scl_q_r;
  assign start_det = scl_f && scl_q_r && sda_q_r && !sda_f;
  assign stop_det = scl_f && scl_q_r && !sda_q_r && sda_f;

  serial_eeprom_pkg::state_t state_r;
  serial_eeprom_pkg::state_t state_nxt;
  serial_eeprom_pkg::role_t role_r;
  serial_eeprom_pkg::role_t role_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic [AW-1:0] hi_r;
  logic [AW-1:0] hi_nxt;
  logic drive_r;
  logic drive_nxt;
  logic rd_r;
  logic rd_nxt;
  logic got_r;
  logic got_nxt;
  logic ack_r;
  logic ack_nxt;
  logic guard_r;
  logic guard_nxt;
  logic [CW-1:0] prog_r;
  logic [CW-1:0] prog_nxt;
  logic [PAGE-1:0] valid_r;
  logic [PAGE-1:0] valid_nxt;
  logic buf_we;
  logic mem_we;
  logic [AW-1:0] mem_waddr;

  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] page_buf [0:PAGE-1];
  logic [7:0] rd_byte;
  logic [2:0] strap;
  assign rd_byte = mem[addr_r];
  assign strap = strap_s2_r;

  // commit one buffered byte per cycle at the start of the program cycle
  assign mem_waddr = {addr_r[AW-1:PW], prog_r[PW-1:0]};
  assign mem_we = (state_r == serial_eeprom_pkg::ST_PROGRAM)
                  && (prog_r < CW'(PAGE))
                  && valid_r[prog_r[PW-1:0]]
                  && !guarded(mem_waddr, guard_r);

  always_comb begin
    state_nxt = state_r;
    role_nxt = role_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    hi_nxt = hi_r;
    drive_nxt = drive_r;
    rd_nxt = rd_r;
    got_nxt = got_r;
    ack_nxt = ack_r;
    guard_nxt = guard_r;
    prog_nxt = prog_r;
    valid_nxt = valid_r;
    buf_we = 1'b0;
    if (state_r == serial_eeprom_pkg::ST_PROGRAM) begin
      // lines are not looked at until the cycle is over
      drive_nxt = 1'b0;
      prog_nxt = prog_r + CW'(1);
      if (prog_r == CW'(PROGRAM_CYC - 1)) begin
        state_nxt = serial_eeprom_pkg::ST_IDLE;
        valid_nxt = '0;
        got_nxt = 1'b0;
      end
    end else if (start_det) begin
      state_nxt = serial_eeprom_pkg::ST_RX_BYTE;
      role_nxt = serial_eeprom_pkg::ROLE_DEV;
      cnt_nxt = 4'h0;
      drive_nxt = 1'b0;
      got_nxt = 1'b0;
    end else if (stop_det) begin
      drive_nxt = 1'b0;
      if (!rd_r && (role_r == serial_eeprom_pkg::ROLE_DATA) && got_r) begin
        state_nxt = serial_eeprom_pkg::ST_PROGRAM;
        prog_nxt = '0;
        guard_nxt = guard_f;
      end else begin
        state_nxt = serial_eeprom_pkg::ST_IDLE;
      end
    end else begin
      case (state_r)
        serial_eeprom_pkg::ST_RX_BYTE: begin
          if (scl_rise && cnt_r < 4'h8) begin
            shift_nxt = {shift_r[6:0], sda_f};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            drive_nxt = 1'b1;
            state_nxt = serial_eeprom_pkg::ST_ACK_OUT;
            case (role_r)
              serial_eeprom_pkg::ROLE_DEV: begin
                if (shift_r[`SEE_TYPE_MSB:`SEE_TYPE_LSB] == TYPE_CODE
                    && shift_r[`SEE_SEL_MSB:`SEE_SEL_LSB] == strap) begin
                  rd_nxt = shift_r[`SEE_DIR_BIT];
                  role_nxt = serial_eeprom_pkg::ROLE_ADDR_HI;
                end else begin
                  drive_nxt = 1'b0;
                  state_nxt = serial_eeprom_pkg::ST_IDLE;
                end
              end
              serial_eeprom_pkg::ROLE_ADDR_HI: begin
                // three top bits of this byte are don't-care
                hi_nxt = {shift_r[`SEE_HI_ADDR_BITS-1:0], 8'h00};
                role_nxt = serial_eeprom_pkg::ROLE_ADDR_LO;
              end
              serial_eeprom_pkg::ROLE_ADDR_LO: begin
                addr_nxt = hi_r | {5'h00, shift_r};
                valid_nxt = '0;
                role_nxt = serial_eeprom_pkg::ROLE_DATA;
              end
              default: begin
                buf_we = 1'b1;
                valid_nxt[addr_r[PW-1:0]] = 1'b1;
                addr_nxt = page_inc(addr_r);
                got_nxt = 1'b1;
              end
            endcase
          end
        end
        serial_eeprom_pkg::ST_ACK_OUT: begin
          if (scl_fall) begin
            if (rd_r && role_r == serial_eeprom_pkg::ROLE_ADDR_HI) begin
              // first data bit goes out on the same fall that ends the ack
              shift_nxt = rd_byte;
              addr_nxt = addr_r + AW'(1);
              drive_nxt = !rd_byte[7];
              cnt_nxt = 4'h0;
              state_nxt = serial_eeprom_pkg::ST_TX_BYTE;
            end else begin
              drive_nxt = 1'b0;
              cnt_nxt = 4'h0;
              state_nxt = serial_eeprom_pkg::ST_RX_BYTE;
            end
          end
        end
        serial_eeprom_pkg::ST_TX_BYTE: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              drive_nxt = 1'b0;
              state_nxt = serial_eeprom_pkg::ST_ACK_IN;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              drive_nxt = !shift_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        serial_eeprom_pkg::ST_ACK_IN: begin
          if (scl_rise) begin
            ack_nxt = sda_f;
          end else if (scl_fall) begin
            if (!ack_r) begin
              shift_nxt = rd_byte;
              addr_nxt = addr_r + AW'(1);
              drive_nxt = !rd_byte[7];
              cnt_nxt = 4'h0;
              state_nxt = serial_eeprom_pkg::ST_TX_BYTE;
            end else begin
              state_nxt = serial_eeprom_pkg::ST_WAIT_STOP;
            end
          end
        end
        serial_eeprom_pkg::ST_WAIT_STOP: begin
          drive_nxt = 1'b0;
        end
        serial_eeprom_pkg::ST_IDLE: begin
          drive_nxt = 1'b0;
        end
        default: begin
          drive_nxt = 1'b0;
          state_nxt = serial_eeprom_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= serial_eeprom_pkg::ST_IDLE;
      role_r <= serial_eeprom_pkg::ROLE_DEV;
      shift_r <= `SEE_BYTE_RST;
      cnt_r <= 4'h0;
      addr_r <= '0;
      hi_r <= '0;
      drive_r <= 1'b0;
      rd_r <= 1'b0;
      got_r <= 1'b0;
      ack_r <= 1'b1;
      guard_r <= 1'b0;
      prog_r <= '0;
      valid_r <= '0;
      scl_q_r <= `SEE_LINE_IDLE;
      sda_q_r <= `SEE_LINE_IDLE;
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      role_r <= role_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      hi_r <= hi_nxt;
      drive_r <= drive_nxt;
      rd_r <= rd_nxt;
      got_r <= got_nxt;
      ack_r <= ack_nxt;
      guard_r <= guard_nxt;
      prog_r <= prog_nxt;
      valid_r <= valid_nxt;
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      strap_s1_r <= {select_strap_2, select_strap_1, select_strap_0};
      strap_s2_r <= strap_s1_r;
    end
  end

  // storage has no reset: contents are meant to survive it
  always_ff @(posedge clk) begin
    if (buf_we) begin
      page_buf[addr_r[PW-1:0]] <= shift_r;
    end
    if (mem_we) begin
      mem[mem_waddr] <= page_buf[prog_r[PW-1:0]];
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_r;
  assign program_busy = (state_r == serial_eeprom_pkg::ST_PROGRAM);

endmodule : serial_eeprom_i2c_target

`default_nettype wire

// ---- serial_eeprom_i2c_target_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_target_sva #(
  parameter int PROGRAM_CYC = 64
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_guard,
  input wire logic select_strap_0,
  input wire logic select_strap_1,
  input wire logic select_strap_2,
  input wire logic program_busy
);
  int busy_r;
  int busy_nxt;
  always_comb begin
    busy_nxt = program_busy ? busy_r + 1 : 0;
  end
  always_ff @(posedge clk) begin
    busy_r <= reset_n ? busy_nxt : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  out_low_a: assert property (sda_out == 1'b0) else $error("sda_out not low");
  reset_idle_a: assert property ($rose(reset_n) |-> !sda_oe && !program_busy)
    else $error("not idle after reset");
  busy_mute_a: assert property (program_busy |-> !sda_oe) else $error("drive while busy");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed with scl high");
  oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("drive too short");
  busy_min_a: assert property ($fell(program_busy) |-> busy_r >= 32)
    else $error("program cycle too short");
  busy_cap_a: assert property (program_busy |-> busy_r < PROGRAM_CYC)
    else $error("program cycle too long");
  busy_start_a: assert property ($rose(program_busy) |-> scl_in && sda_in)
    else $error("program cycle without stop");
endmodule : serial_eeprom_i2c_target_sva
bind serial_eeprom_i2c_target serial_eeprom_i2c_target_sva #(.PROGRAM_CYC(PROGRAM_CYC)) sva_inst (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_guard(write_guard), .select_strap_0(select_strap_0),
  .select_strap_1(select_strap_1), .select_strap_2(select_strap_2),
  .program_busy(program_busy));
`default_nettype wire

// ---- serial_eeprom_i2c_target_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_target_test;
  localparam int PCYC = 64;
  // arbitrary type code
  localparam logic [3:0] DEV_TYPE = 4'h5;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic guard = 1'b0;
  logic [2:0] strap = 3'h0;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic k;
  logic [31:0] seed = 32'h16;
  logic [7:0] mem [0:8191];
  logic [12:0] ptr;
  int errors = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  serial_eeprom_i2c_target #(.TYPE_CODE(DEV_TYPE), .PROGRAM_CYC(PCYC))
    serial_eeprom_i2c_target_inst (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_guard(guard), .select_strap_0(strap[0]),
    .select_strap_1(strap[1]), .select_strap_2(strap[2]), .program_busy(busy));
  bus_controller bus_controller_inst (.clk(clk), .dev_oe(sda_oe), .dev_out(sda_out),
    .scl(scl), .sda(sda));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic dev(input logic [3:0] ty, input logic [2:0] sel, input logic dir, output logic a);
    logic [7:0] q;
    bus_controller_inst.start();
    bus_controller_inst.io({ty, sel, dir}, 1'b1, q, a);
  endtask : dev
  task automatic wr(input logic [12:0] a, input int n, input logic g);
    logic [7:0] q;
    logic [7:0] d;
    logic acc;
    guard <= g;
    dev(DEV_TYPE, strap, 1'b0, acc);
    bus_controller_inst.io({3'h7, a[12:8]}, 1'b1, q, k);
    acc |= k;
    bus_controller_inst.io(a[7:0], 1'b1, q, k);
    acc |= k;
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      if (i == 1) bus_controller_inst.glitch();
      bus_controller_inst.io(d, 1'b1, q, k);
      acc |= k;
      if (!(g && a >= 13'h1800)) mem[a] = d;
      a = {a[12:5], a[4:0] + 5'h01};
      ptr = a;
    end
    bus_controller_inst.stop();
    check("write acks", 8'h00, 8'(acc));
    check("busy", 8'h01, 8'(busy));
    k = 1'b1;
    for (int p = 0; p < 10 && k; p++) begin
      dev(DEV_TYPE, strap, 1'b0, k);
      bus_controller_inst.stop();
      if (p == 0) check("poll busy", 8'h01, 8'(k));
    end
    check("poll done", 8'h00, 8'(k));
  endtask : wr
  task automatic rd(input logic by_addr, input logic [12:0] a, input int n);
    logic [7:0] q;
    if (by_addr) begin
      dev(DEV_TYPE, strap, 1'b0, k);
      bus_controller_inst.io({3'h0, a[12:8]}, 1'b1, q, k);
      bus_controller_inst.io(a[7:0], 1'b1, q, k);
      ptr = a;
    end
    dev(DEV_TYPE, strap, 1'b1, k);
    check("read ack", 8'h00, 8'(k));
    for (int i = 0; i < n; i++) begin
      bus_controller_inst.io(8'hFF, i == n - 1, q, k);
      check("read data", mem[ptr], q);
      ptr = ptr + 13'h0001;
    end
    bus_controller_inst.io(8'hFF, 1'b1, q, k);
    check("released", 8'hFF, q);
    bus_controller_inst.stop();
  endtask : rd
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    strap <= 3'(rnd());
    repeat (8) @(posedge clk);
    dev(DEV_TYPE, strap ^ 3'h2, 1'b0, k);
    check("strap mismatch", 8'h01, 8'(k));
    bus_controller_inst.stop();
    dev(DEV_TYPE ^ 4'h3, strap, 1'b1, k);
    check("type mismatch", 8'h01, 8'(k));
    bus_controller_inst.stop();
    wr({1'b0, 7'(rnd()), 5'h1E}, 34, 1'b0);
    rd(1'b0, 13'h0000, 3);
    bus_controller_inst.hl = 17;
    wr(13'h1FFE, 2, 1'b0);
    wr(13'h0000, 2, 1'b0);
    wr(13'h1FFE, 2, 1'b1);
    wr(13'h0000, 2, 1'b1);
    rd(1'b1, 13'h1FFE, 4);
    conclude();
  end
endmodule : serial_eeprom_i2c_target_test
`default_nettype wire

// ---- serial_eeprom_pkg.sv ----
package serial_eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX_BYTE,
    ST_ACK_OUT,
    ST_TX_BYTE,
    ST_ACK_IN,
    ST_WAIT_STOP,
    ST_PROGRAM
  } state_t;

  typedef enum logic [1:0] {
    ROLE_DEV,
    ROLE_ADDR_HI,
    ROLE_ADDR_LO,
    ROLE_DATA
  } role_t;

endpackage : serial_eeprom_pkg
